// ===== dtc_pkg.sv
// Constants, types and register map of the dual timer/counter block
package dtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_RUN_FLAG_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h89;
  localparam logic [7:0] ADDR_A_COUNT_LOW = 8'h8a;
  localparam logic [7:0] ADDR_B_COUNT_LOW = 8'h8b;
  localparam logic [7:0] ADDR_A_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_B_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h8e;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_B_OVERFLOW = 7;
  localparam int BIT_B_RUN = 6;
  localparam int BIT_A_OVERFLOW = 5;
  localparam int BIT_A_RUN = 4;
  localparam int BIT_EXT_B_FLAG = 3;
  localparam int BIT_EXT_B_EDGE = 2;
  localparam int BIT_EXT_A_FLAG = 1;
  localparam int BIT_EXT_A_EDGE = 0;
  localparam int MODE_B_BASE = 4;
  localparam int MODE_A_BASE = 0;
  localparam int FLD_GATE = 3;
  localparam int FLD_COUNTER_SEL = 2;
  localparam int FLD_MODE_HIGH = 1;
  localparam int FLD_MODE_LOW = 0;
  localparam int BIT_B_FAST_CLOCK = 4;
  localparam int BIT_A_FAST_CLOCK = 3;
  localparam logic [7:0] CLK_CFG_MASK = 8'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] RST_RUN_FLAG = 8'h00;
  localparam logic [7:0] RST_MODE_CFG = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CLK_CFG = 8'h01;
  localparam logic [3:0] RST_PIN_IDLE = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  localparam logic [3:0] PRESC_LAST = 4'(DIV_SLOW - 1);
  localparam logic [1:0] FAST_LAST = 2'(DIV_FAST - 1);
  localparam logic [4:0] PRESC13_LAST = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_PRESC13 = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dtc_sfr_req_s;

  typedef struct packed {
    logic timer_a;
    logic timer_b;
    logic ext_a;
    logic ext_b;
  } dtc_svc_s;

endpackage

// ===== dtc_timer_core.sv
// One timer count pair with its four operating modes
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode and count events
  input wire dtc_pkg::dtc_mode_e mode,
  input wire logic split_en,
  input wire logic tick_low,
  input wire logic tick_high,
  // Software writes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  // Count and overflow
  output logic [7:0] cnt_low,
  output logic [7:0] cnt_high,
  output logic ovf,
  output logic ovf_high
);

  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next count
  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    ovf = 1'b0;
    ovf_high = 1'b0;
    case (mode)
      dtc_pkg::MODE_PRESC13: begin
        if (tick_low) begin
          low_next = {low_reg[7:5], 5'(low_reg[4:0] + 5'h1)};
          if (low_reg[4:0] == dtc_pkg::PRESC13_LAST) begin
            high_next = 8'(high_reg + 8'h1);
            ovf = (high_reg == 8'hff);
          end
        end
      end
      dtc_pkg::MODE_16BIT: begin
        if (tick_low) begin
          {high_next, low_next} = 16'({high_reg, low_reg} + 16'h1);
          ovf = &{high_reg, low_reg};
        end
      end
      dtc_pkg::MODE_RELOAD: begin
        if (tick_low) begin
          if (low_reg == 8'hff) begin
            low_next = high_reg;
            ovf = 1'b1;
          end else begin
            low_next = 8'(low_reg + 8'h1);
          end
        end
      end
      dtc_pkg::MODE_SPLIT: begin
        if (split_en && tick_low) begin
          low_next = 8'(low_reg + 8'h1);
          ovf = (low_reg == 8'hff);
        end
        if (split_en && tick_high) begin
          high_next = 8'(high_reg + 8'h1);
          ovf_high = (high_reg == 8'hff);
        end
      end
      default: begin
      end
    endcase
    if (wr_low) begin
      low_next = wdata;
    end
    if (wr_high) begin
      high_next = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_reg <= dtc_pkg::RST_COUNT;
      high_reg <= dtc_pkg::RST_COUNT;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  assign cnt_low = low_reg;
  assign cnt_high = high_reg;

endmodule
`default_nettype wire

// ===== dtc_timer_top.sv
// Dual timer/counter with gating, clock select and external pin flags
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // Special function register port
  input wire dtc_pkg::dtc_sfr_req_s SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  // Service entry from the core
  input wire dtc_pkg::dtc_svc_s SVC_ACK,
  // Device pins
  input wire logic TIMER_A_COUNT_PIN,
  input wire logic TIMER_B_COUNT_PIN,
  input wire logic EXT_IRQ_A_PIN,
  input wire logic EXT_IRQ_B_PIN,
  // Flags to the interrupt logic
  output logic TIMER_A_OVERFLOW_FLAG,
  output logic TIMER_B_OVERFLOW_FLAG,
  output logic EXT_IRQ_A_FLAG,
  output logic EXT_IRQ_B_FLAG
);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] last_reg;
  logic [3:0] fall;
  logic [3:0] presc_reg;
  logic tick12;
  logic tick4;
  logic [7:0] mode_reg;
  logic [7:0] clk_cfg_reg;
  logic run_a_reg, run_b_reg, ovf_a_reg, ovf_b_reg;
  logic ext_a_reg, ext_b_reg, edge_a_reg, edge_b_reg;
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic wr_ctrl, wr_a_low, wr_a_high, wr_b_low, wr_b_high;
  logic [7:0] wd;
  dtc_pkg::dtc_mode_e mode_a, mode_b;
  logic gate_a, gate_b, ct_a, ct_b, fast_a, fast_b;
  logic tick_a, tick_b, evt_a, evt_b, split_tick;
  logic ovf_a_evt, ovf_b_evt, core_b_ovf, core_a_ovf_high;
  logic [7:0] a_low, a_high, b_low, b_high;
  logic [15:0] cnt_a, cnt_b;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; bit order is count A, count B, irq A, irq B
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync1_reg <= dtc_pkg::RST_PIN_IDLE;
      sync2_reg <= dtc_pkg::RST_PIN_IDLE;
      last_reg <= dtc_pkg::RST_PIN_IDLE;
    end else begin
      sync1_reg <= {EXT_IRQ_B_PIN, EXT_IRQ_A_PIN, TIMER_B_COUNT_PIN, TIMER_A_COUNT_PIN};
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  assign fall = last_reg & ~sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Internal tick prescaler
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      presc_reg <= 4'h0;
    end else if (presc_reg == dtc_pkg::PRESC_LAST) begin
      presc_reg <= 4'h0;
    end else begin
      presc_reg <= 4'(presc_reg + 4'h1);
    end
  end

  assign tick12 = (presc_reg == dtc_pkg::PRESC_LAST);
  assign tick4 = (presc_reg[1:0] == dtc_pkg::FAST_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wd = SFR_REQ.wdata;
  assign wr_ctrl = SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_RUN_FLAG_CTRL);
  assign wr_a_low = SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_A_COUNT_LOW);
  assign wr_a_high = SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_A_COUNT_HIGH);
  assign wr_b_low = SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_B_COUNT_LOW);
  assign wr_b_high = SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_B_COUNT_HIGH);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mode_reg <= dtc_pkg::RST_MODE_CFG;
      clk_cfg_reg <= dtc_pkg::RST_CLK_CFG;
    end else begin
      if (SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_MODE_CFG)) begin
        mode_reg <= wd;
      end
      if (SFR_REQ.wr && (SFR_REQ.addr == dtc_pkg::ADDR_CLK_CFG)) begin
        clk_cfg_reg <= wd & dtc_pkg::CLK_CFG_MASK;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      run_a_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_A_RUN];
      run_b_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_B_RUN];
      edge_a_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_EXT_A_EDGE];
      edge_b_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_EXT_B_EDGE];
    end else if (wr_ctrl) begin
      run_a_reg <= wd[dtc_pkg::BIT_A_RUN];
      run_b_reg <= wd[dtc_pkg::BIT_B_RUN];
      edge_a_reg <= wd[dtc_pkg::BIT_EXT_A_EDGE];
      edge_b_reg <= wd[dtc_pkg::BIT_EXT_B_EDGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode fields and count events
  assign mode_a = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::MODE_A_BASE +: 2]);
  assign mode_b = dtc_pkg::dtc_mode_e'(mode_reg[dtc_pkg::MODE_B_BASE +: 2]);
  assign gate_a = mode_reg[dtc_pkg::MODE_A_BASE + dtc_pkg::FLD_GATE];
  assign gate_b = mode_reg[dtc_pkg::MODE_B_BASE + dtc_pkg::FLD_GATE];
  assign ct_a = mode_reg[dtc_pkg::MODE_A_BASE + dtc_pkg::FLD_COUNTER_SEL];
  assign ct_b = mode_reg[dtc_pkg::MODE_B_BASE + dtc_pkg::FLD_COUNTER_SEL];
  assign fast_a = clk_cfg_reg[dtc_pkg::BIT_A_FAST_CLOCK];
  assign fast_b = clk_cfg_reg[dtc_pkg::BIT_B_FAST_CLOCK];

  assign tick_a = fast_a ? tick4 : tick12;
  assign tick_b = fast_b ? tick4 : tick12;
  assign evt_a = run_a_reg && (!gate_a || sync2_reg[2]) && (ct_a ? fall[0] : tick_a);
  assign evt_b = run_b_reg && (!gate_b || sync2_reg[3]) && (ct_b ? fall[1] : tick_b);
  assign split_tick = run_b_reg && tick_a;

  ////////////////////////////////////////////////////////////////////////////
  // Count pairs
  dtc_timer_core u_timer_a (
    .clk(REF_CLK),
    .rst(RESET),
    .mode(mode_a),
    .split_en(1'b1),
    .tick_low(evt_a),
    .tick_high(split_tick),
    .wr_low(wr_a_low),
    .wr_high(wr_a_high),
    .wdata(wd),
    .cnt_low(a_low),
    .cnt_high(a_high),
    .ovf(ovf_a_evt),
    .ovf_high(core_a_ovf_high)
  );

  dtc_timer_core u_timer_b (
    .clk(REF_CLK),
    .rst(RESET),
    .mode(mode_b),
    .split_en(1'b0),
    .tick_low(evt_b),
    .tick_high(1'b0),
    .wr_low(wr_b_low),
    .wr_high(wr_b_high),
    .wdata(wd),
    .cnt_low(b_low),
    .cnt_high(b_high),
    .ovf(core_b_ovf),
    .ovf_high()
  );

  assign cnt_a = {a_high, a_low};
  assign cnt_b = {b_high, b_low};
  assign ovf_b_evt = (mode_a == dtc_pkg::MODE_SPLIT) ? core_a_ovf_high : core_b_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Overflow and external flags; a hardware set wins over any clear
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ovf_a_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_A_OVERFLOW];
      ovf_b_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_B_OVERFLOW];
    end else begin
      ovf_a_reg <= ovf_a_evt ||
        (wr_ctrl ? wd[dtc_pkg::BIT_A_OVERFLOW] : (ovf_a_reg && !SVC_ACK.timer_a));
      ovf_b_reg <= ovf_b_evt ||
        (wr_ctrl ? wd[dtc_pkg::BIT_B_OVERFLOW] : (ovf_b_reg && !SVC_ACK.timer_b));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ext_a_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_EXT_A_FLAG];
      ext_b_reg <= dtc_pkg::RST_RUN_FLAG[dtc_pkg::BIT_EXT_B_FLAG];
    end else begin
      if (edge_a_reg) begin
        ext_a_reg <= fall[2] ||
          (wr_ctrl ? wd[dtc_pkg::BIT_EXT_A_FLAG] : (ext_a_reg && !SVC_ACK.ext_a));
      end else begin
        ext_a_reg <= !sync2_reg[2];
      end
      if (edge_b_reg) begin
        ext_b_reg <= fall[3] ||
          (wr_ctrl ? wd[dtc_pkg::BIT_EXT_B_FLAG] : (ext_b_reg && !SVC_ACK.ext_b));
      end else begin
        ext_b_reg <= !sync2_reg[3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= (SFR_REQ.rd || SFR_REQ.wr) &&
        (SFR_REQ.addr >= dtc_pkg::ADDR_RUN_FLAG_CTRL) && (SFR_REQ.addr <= dtc_pkg::ADDR_CLK_CFG);
      if (SFR_REQ.rd) begin
        case (SFR_REQ.addr)
          dtc_pkg::ADDR_RUN_FLAG_CTRL: rdata_reg <= {ovf_b_reg, run_b_reg, ovf_a_reg, run_a_reg,
            ext_b_reg, edge_b_reg, ext_a_reg, edge_a_reg};
          dtc_pkg::ADDR_MODE_CFG: rdata_reg <= mode_reg;
          dtc_pkg::ADDR_A_COUNT_LOW: rdata_reg <= a_low;
          dtc_pkg::ADDR_B_COUNT_LOW: rdata_reg <= b_low;
          dtc_pkg::ADDR_A_COUNT_HIGH: rdata_reg <= a_high;
          dtc_pkg::ADDR_B_COUNT_HIGH: rdata_reg <= b_high;
          dtc_pkg::ADDR_CLK_CFG: rdata_reg <= clk_cfg_reg;
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign SFR_HIT = hit_reg;
  assign TIMER_A_OVERFLOW_FLAG = ovf_a_reg;
  assign TIMER_B_OVERFLOW_FLAG = ovf_b_reg;
  assign EXT_IRQ_A_FLAG = ext_a_reg;
  assign EXT_IRQ_B_FLAG = ext_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_slow_gap;
    !tick12 [*8] ##1 !tick12 [*3] ##1 tick12;
  endsequence

  sequence s_fast_gap;
    !tick4 [*3] ##1 tick4;
  endsequence

  a_gate_holds_b: assert property (
    ((!run_b_reg || (gate_b && !sync2_reg[3])) && !wr_b_low && !wr_b_high)
    |=> $stable(cnt_b))
    else $error("timer B moved while halted or gated");

  a_gate_holds_a: assert property (
    ((!run_a_reg || (gate_a && !sync2_reg[2])) && mode_a != dtc_pkg::MODE_SPLIT &&
     !wr_a_low && !wr_a_high) |=> $stable(cnt_a))
    else $error("timer A moved while halted or gated");

  a_internal_count_b: assert property (
    (run_b_reg && !gate_b && !ct_b && fast_b && tick4 && mode_b == dtc_pkg::MODE_16BIT &&
     !wr_b_low && !wr_b_high) |=> (cnt_b == 16'($past(cnt_b) + 16'h1)))
    else $error("timer B missed an internal tick");

  a_pin_count_a: assert property (
    (ct_a && !fall[0] && mode_a == dtc_pkg::MODE_16BIT && !wr_a_low && !wr_a_high)
    |=> $stable(cnt_a))
    else $error("timer A counted without a pin pulse");

  a_reload_b: assert property (
    (evt_b && mode_b == dtc_pkg::MODE_RELOAD && mode_a != dtc_pkg::MODE_SPLIT &&
     b_low == 8'hff && !wr_b_low && !wr_b_high)
    |=> (b_low == $past(b_high)) && TIMER_B_OVERFLOW_FLAG)
    else $error("timer B reload failed");

  a_presc_carry_a: assert property (
    (evt_a && mode_a == dtc_pkg::MODE_PRESC13 && a_low[4:0] == 5'h1f &&
     !wr_a_low && !wr_a_high) |=> (a_low[4:0] == 5'h00) && (a_high == 8'($past(a_high) + 8'h1)))
    else $error("timer A prescale carry failed");

  a_mode3_hold_b: assert property (
    (mode_b == dtc_pkg::MODE_SPLIT && !wr_b_low && !wr_b_high) |=> $stable(cnt_b))
    else $error("timer B counted in mode three");

  a_split_high_a: assert property (
    (mode_a == dtc_pkg::MODE_SPLIT && run_b_reg && tick_a && !wr_a_high)
    |=> (a_high == 8'($past(a_high) + 8'h1)))
    else $error("timer A high byte missed a split tick");

  a_read_count_a: assert property (
    (SFR_REQ.rd && SFR_REQ.addr == dtc_pkg::ADDR_A_COUNT_HIGH) |=> (SFR_RDATA == $past(a_high)))
    else $error("timer A high byte read wrong");

  a_read_count_b: assert property (
    (SFR_REQ.rd && SFR_REQ.addr == dtc_pkg::ADDR_B_COUNT_LOW) |=> (SFR_RDATA == $past(b_low)))
    else $error("timer B low byte read wrong");

  a_slow_period: assert property (
    tick12 |=> s_slow_gap)
    else $error("slow tick period is not twelve");

  a_fast_period: assert property (
    tick4 |=> s_fast_gap)
    else $error("fast tick period is not four");

  a_overflow_flag: assert property (
    (ovf_a_evt |=> TIMER_A_OVERFLOW_FLAG) and
    ((SVC_ACK.timer_a && !ovf_a_evt && !wr_ctrl) |=> !TIMER_A_OVERFLOW_FLAG))
    else $error("timer A overflow flag wrong");

  a_ext_edge_flag: assert property (
    (edge_b_reg && fall[3]) |=> EXT_IRQ_B_FLAG)
    else $error("external B edge not flagged");

  a_ext_level_flag: assert property (
    !edge_a_reg |=> (EXT_IRQ_A_FLAG == !$past(sync2_reg[2])))
    else $error("external A level flag wrong");

endmodule
`default_nettype wire

// ===== dtc_timer_top_tb.sv
// Self-checking testbench of the dual timer/counter block
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_top_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  dtc_pkg::dtc_sfr_req_s req = '0;
  dtc_pkg::dtc_svc_s svc = '0;
  logic [1:0] cnt_pin = 2'h3;
  logic [1:0] irq_pin = 2'h3;
  logic [7:0] rdata;
  logic hit;
  logic [1:0] ovf_flag;
  logic [1:0] ext_flag;
  logic [7:0] v;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  dtc_timer_top DUT (
    .REF_CLK(ref_clk), .RESET(reset), .SFR_REQ(req), .SFR_RDATA(rdata), .SFR_HIT(hit),
    .SVC_ACK(svc), .TIMER_A_COUNT_PIN(cnt_pin[0]), .TIMER_B_COUNT_PIN(cnt_pin[1]),
    .EXT_IRQ_A_PIN(irq_pin[0]), .EXT_IRQ_B_PIN(irq_pin[1]),
    .TIMER_A_OVERFLOW_FLAG(ovf_flag[0]), .TIMER_B_OVERFLOW_FLAG(ovf_flag[1]),
    .EXT_IRQ_A_FLAG(ext_flag[0]), .EXT_IRQ_B_FLAG(ext_flag[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi,
                     input string s);
    samples_checked++;
    if ((^got) === 1'bx || got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h, want %h..%h", $time, s, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge ref_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
    h = hit;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi,
                      input string s);
    logic h;
    rd(a, v, h);
    chk(v, lo, hi, s);
  endtask

  task automatic set_pin(input bit irq, input int t, input logic val);
    logic [1:0] m;
    m = 2'h1 << t;
    @(posedge ref_clk);
    if (irq) begin
      irq_pin <= val ? (irq_pin | m) : (irq_pin & ~m);
    end else begin
      cnt_pin <= val ? (cnt_pin | m) : (cnt_pin & ~m);
    end
  endtask

  task automatic svc_pulse(input logic [3:0] s);
    @(posedge ref_clk);
    svc <= s;
    @(posedge ref_clk);
    svc <= '0;
    #1;
  endtask

  task automatic run_win(input logic [7:0] on, input int n, input logic [7:0] off);
    wr(8'h88, on);
    cyc(n);
    wr(8'h88, off);
  endtask

  task automatic run_flag(input int t, input int n, input logic [7:0] flg, input string s);
    wr(8'h88, 8'h10 << (2 * t));
    cyc(n);
    #1;
    chk({7'h0, ovf_flag[t]}, 8'h01, 8'h01, s);
    wr(8'h88, flg);
  endtask

  task automatic setup(input int t, input logic [7:0] md, input logic [7:0] ck,
                       input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h89, md);
    wr(8'h8e, ck);
    wr(8'h8a + 8'(t), lo);
    wr(8'h8c + 8'(t), hi);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_regs();
    logic h;
    rd(8'h8f, v, h);
    chk(v, 8'h00, 8'h00, "unmapped read data");
    chk({7'h0, h}, 8'h00, 8'h00, "unmapped hit");
    for (int i = 0; i < 7; i++) begin
      rd(8'h88 + 8'(i), v, h);
      chk(v, (i == 6) ? 8'h01 : 8'h00, (i == 6) ? 8'h01 : 8'h00, "reset value");
      chk({7'h0, h}, 8'h01, 8'h01, "mapped hit");
    end
    for (int i = 2; i < 6; i++) wr(8'h88 + 8'(i), 8'ha0 + 8'(i));
    for (int i = 2; i < 6; i++) rchk(8'h88 + 8'(i), 8'ha0 + 8'(i), 8'ha0 + 8'(i), "map");
    wr(8'h8e, 8'hff);
    rchk(8'h8e, 8'h3f, 8'h3f, "clock config readback");
  endtask

  task automatic s_rate(input int t);
    logic [7:0] first;
    setup(t, 8'h11, 8'h00, 8'h00, 8'h00);
    run_win(8'h10 << (2 * t), 120, 8'h00);
    rchk(8'h8a + 8'(t), 8'd9, 8'd11, "divide by 12 rate");
    setup(t, 8'h11, 8'h08 << t, 8'h00, 8'h00);
    run_win(8'h10 << (2 * t), 120, 8'h00);
    rchk(8'h8a + 8'(t), 8'd29, 8'd32, "divide by 4 rate");
    first = v;
    rchk(8'h8c + 8'(t), 8'h00, 8'h00, "16-bit high byte");
    cyc(20);
    rchk(8'h8a + 8'(t), first, first, "halted count kept");
  endtask

  task automatic s_wrap(input int t);
    logic [7:0] run;
    logic [7:0] flg;
    run = 8'h10 << (2 * t);
    flg = 8'h20 << (2 * t);
    setup(t, 8'h00, 8'h08 << t, 8'hff, 8'h00);
    run_win(run, 4, 8'h00);
    rchk(8'h8a + 8'(t), 8'he0, 8'he1, "prescale low byte");
    rchk(8'h8c + 8'(t), 8'h01, 8'h01, "prescale carry");
    setup(t, 8'h22, 8'h08 << t, 8'hfe, 8'hf0);
    run_flag(t, 8, flg, "overflow during reload");
    rchk(8'h8a + 8'(t), 8'hf0, 8'hf1, "reload value");
    rchk(8'h8c + 8'(t), 8'hf0, 8'hf0, "reload byte kept");
    chk({7'h0, ovf_flag[t]}, 8'h01, 8'h01, "overflow flag set");
    rchk(8'h88, flg, flg, "overflow flag in control");
    svc_pulse(4'h8 >> t);
    chk({7'h0, ovf_flag[t]}, 8'h00, 8'h00, "service clears flag");
    setup(t, 8'h11, 8'h08 << t, 8'hff, 8'hff);
    run_flag(t, 4, flg, "overflow during 16-bit wrap");
    rchk(8'h8a + 8'(t), 8'h00, 8'h01, "16-bit wrap low");
    rchk(8'h8c + 8'(t), 8'h00, 8'h00, "16-bit wrap high");
    chk({7'h0, ovf_flag[t]}, 8'h01, 8'h01, "16-bit overflow flag");
    wr(8'h88, 8'h00);
    #1;
    chk({7'h0, ovf_flag[t]}, 8'h00, 8'h00, "software clears flag");
  endtask

  task automatic s_gate(input int t);
    setup(t, 8'h09 << (4 * t), 8'h08 << t, 8'h00, 8'h00);
    set_pin(1'b1, t, 1'b0);
    cyc(3);
    run_win(8'h10 << (2 * t), 40, 8'h00);
    rchk(8'h8a + 8'(t), 8'h00, 8'h00, "gated off by low pin");
    set_pin(1'b1, t, 1'b1);
    cyc(3);
    run_win(8'h10 << (2 * t), 40, 8'h00);
    rchk(8'h8a + 8'(t), 8'd9, 8'd12, "gated on by high pin");
    setup(t, 8'h01 << (4 * t), 8'h08 << t, 8'h00, 8'h00);
    set_pin(1'b1, t, 1'b0);
    cyc(3);
    run_win(8'h10 << (2 * t), 40, 8'h00);
    rchk(8'h8a + 8'(t), 8'd9, 8'd12, "pin ignored without gate");
    set_pin(1'b1, t, 1'b1);
  endtask

  task automatic s_count(input int t);
    setup(t, 8'h05 << (4 * t), 8'h08 << t, 8'h00, 8'h00);
    wr(8'h88, 8'h10 << (2 * t));
    repeat (5) begin
      set_pin(1'b0, t, 1'b0);
      cyc(3);
      set_pin(1'b0, t, 1'b1);
      cyc(3);
    end
    wr(8'h88, 8'h00);
    cyc(6);
    rchk(8'h8a + 8'(t), 8'h05, 8'h05, "pin pulses counted");
    repeat (3) begin
      set_pin(1'b0, t, 1'b0);
      cyc(3);
      set_pin(1'b0, t, 1'b1);
      cyc(3);
    end
    rchk(8'h8a + 8'(t), 8'h05, 8'h05, "pulses ignored when halted");
  endtask

  task automatic s_ext(input int t);
    wr(8'h88, 8'h01 << (2 * t));
    set_pin(1'b1, t, 1'b0);
    cyc(6);
    set_pin(1'b1, t, 1'b1);
    cyc(6);
    chk({7'h0, ext_flag[t]}, 8'h01, 8'h01, "falling edge latched");
    svc_pulse(4'h2 >> t);
    chk({7'h0, ext_flag[t]}, 8'h00, 8'h00, "service clears edge flag");
    wr(8'h88, 8'h00);
    set_pin(1'b1, t, 1'b0);
    cyc(6);
    chk({7'h0, ext_flag[t]}, 8'h01, 8'h01, "low level flagged");
    set_pin(1'b1, t, 1'b1);
    cyc(6);
    chk({7'h0, ext_flag[t]}, 8'h00, 8'h00, "level flag follows pin");
  endtask

  task automatic s_hold();
    setup(1, 8'h31, 8'h10, 8'h05, 8'h06);
    run_win(8'h40, 40, 8'h00);
    rchk(8'h8b, 8'h05, 8'h05, "mode 3 low held");
    rchk(8'h8d, 8'h06, 8'h06, "mode 3 high held");
  endtask

  task automatic s_split();
    logic [7:0] high;
    setup(0, 8'h03, 8'h08, 8'h00, 8'h00);
    run_win(8'h40, 40, 8'h00);
    rchk(8'h8c, 8'd9, 8'd12, "split high byte counts");
    high = v;
    rchk(8'h8a, 8'h00, 8'h00, "split low byte idle");
    run_win(8'h10, 40, 8'h00);
    rchk(8'h8a, 8'd9, 8'd12, "split low byte counts");
    rchk(8'h8c, high, high, "split high byte idle");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    cyc(8);
    reset <= 1'b0;
    s_regs();
    for (int t = 0; t < 2; t++) begin
      s_rate(t);
      s_wrap(t);
      s_gate(t);
      s_count(t);
      s_ext(t);
    end
    s_hold();
    s_split();
    results();
  end

  initial begin
    cyc(20000);
    error_cnt++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end
endmodule
`default_nettype wire
